// >>> rtl/awt_defs.svh
`ifndef AWT_DEFS_SVH
`define AWT_DEFS_SVH

// register indexes; byte address is four times the index
`define AWT_IDX_DATA 4'h0
`define AWT_IDX_FEAT 4'h1
`define AWT_IDX_SC 4'h2
`define AWT_IDX_SN 4'h3
`define AWT_IDX_CYL 4'h4
`define AWT_IDX_CYH 4'h5
`define AWT_IDX_DH 4'h6
`define AWT_IDX_CMD 4'h7
`define AWT_IDX_CFG 4'h8

// opcodes
`define AWT_OP_TRANSLATE 8'h87
`define AWT_OP_WEAR 8'hF5
`define AWT_OP_WBUF 8'hE8
`define AWT_OP_WDMA 8'hCA
`define AWT_OP_WMULT 8'hC5

// status and error bit positions
`define AWT_ST_BSY 7
`define AWT_ST_RDY 6
`define AWT_ST_DRQ 3
`define AWT_ST_ERR 0
`define AWT_ER_ABRT 2
`define AWT_ER_WRF 6

// drive/head layout
`define AWT_DH_LBA 6
`define AWT_DH_DRV 4
`define AWT_DH_FIXED 8'hA0

// config register fields
`define AWT_CFG_8BIT 0
`define AWT_CFG_MEN 1
`define AWT_CFG_CNT_LSB 8

// reset values
`define AWT_SC_RST 8'h01
`define AWT_SN_RST 8'h01
`define AWT_DH_RST 8'hA0

// translate buffer byte positions
`define AWT_TB_ERASED 9'h013
`define AWT_TB_HOT0 9'h018
`define AWT_TB_HOT1 9'h019
`define AWT_TB_HOT2 9'h01A

// timing
`define AWT_CLK_NS 10
`define AWT_BSY_MAX_NS 400
`define AWT_BSY_MAX_CYC (`AWT_BSY_MAX_NS / `AWT_CLK_NS)
`define AWT_SETUP_CYC 6'h02
`define AWT_LAST_WORD 8'hFF

`endif

// >>> rtl/awt_pkg.sv
package awt_pkg;

	typedef enum logic [2:0] {
		AWT_IDLE = 3'b000,
		AWT_SETUP = 3'b001,
		AWT_XFER = 3'b010,
		AWT_PROG = 3'b011,
		AWT_TRANS = 3'b100
	} awt_state_t;

	typedef struct packed {
		logic [7:0] feat;
		logic [7:0] sc;
		logic [7:0] sn;
		logic [7:0] cyl;
		logic [7:0] cyh;
		logic [7:0] dh;
	} awt_tf_t;

	typedef struct packed {
		logic req;
		logic [27:0] lba;
	} awt_media_t;

	typedef struct packed {
		awt_state_t st;
		awt_tf_t tf;
		logic [7:0] cmd;
		logic [7:0] err;
		logic bsy;
		logic drq;
		logic errf;
		logic intrq;
		logic dmarq;
		logic eight_bit;
		logic mult_en;
		logic [7:0] mult_cnt;
		logic is_dma;
		logic err_pend;
		logic first_blk;
		logic blk_start;
		logic [8:0] left;
		logic [8:0] blk_left;
		logic [7:0] widx;
		logic [5:0] dly;
		logic [2:0] s_ack;
		logic [2:0] s_iowr;
		logic ack_f;
		logic iowr_f;
		logic [15:0] d1;
		logic [15:0] d2;
		logic [15:0] d3;
		logic [15:0] dlat;
		logic wr_pend;
		logic [3:0] wr_idx;
		logic [31:0] hrdata;
		logic [15:0] mrd;
		logic [255:0][15:0] wbuf;
	} awt_st_t;

endpackage : awt_pkg

// >>> rtl/awt_cmd.sv
`timescale 1ns/1ps
`include "awt_defs.svh"

module awt_cmd import awt_pkg::*; #(
	parameter int MAX_MULT = 1,
	parameter int HEADS = 16,
	parameter int SPT = 63,
	parameter logic DRIVE_ID = 1'b0
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	output logic dmarq_o,
	input wire logic dmack_n_i,
	input wire logic iowr_n_i,
	input wire logic [15:0] dd_i,
	output logic intrq_o,
	output awt_media_t media_o,
	input wire logic media_done_i,
	input wire logic media_err_i,
	input wire logic [7:0] media_idx_i,
	output logic [15:0] media_data_o,
	input wire logic erased_i,
	input wire logic [23:0] hot_count_i,
	input wire logic hot_valid_i
);

	localparam int BSY_CYC = `AWT_BSY_MAX_CYC;

	generate
		if (MAX_MULT < 1 || MAX_MULT > 255 || HEADS < 1 || HEADS > 16 || SPT < 1 || SPT > 255)
		begin : g_bad
			$error("awt_cmd: unsupported geometry or block count");
		end
	endgenerate

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [27:0] lba_of(input awt_tf_t tf);
		if (tf.dh[`AWT_DH_LBA]) begin
			return {tf.dh[3:0], tf.cyh, tf.cyl, tf.sn};
		end
		return 28'((int'({tf.cyh, tf.cyl}) * HEADS + int'(tf.dh[3:0])) * SPT
			+ int'(tf.sn) - 1);
	endfunction : lba_of

	function automatic logic [7:0] tbyte(input awt_tf_t tf, input logic [8:0] a,
			input logic erased, input logic [23:0] hot, input logic hot_ok);
		logic [27:0] l;
		logic [15:0] c;
		logic [7:0] h;
		logic [7:0] s;
		l = lba_of(tf);
		c = {tf.cyh, tf.cyl};
		h = {4'h0, tf.dh[3:0]};
		s = tf.sn;
		if (tf.dh[`AWT_DH_LBA]) begin
			c = 16'(int'(l) / (HEADS * SPT));
			h = 8'((int'(l) / SPT) % HEADS);
			s = 8'(int'(l) % SPT + 1);
		end
		case (a)
			9'h000: return c[15:8];
			9'h001: return c[7:0];
			9'h002: return h;
			9'h003: return s;
			9'h004: return l[23:16];
			9'h005: return l[15:8];
			9'h006: return l[7:0];
			`AWT_TB_ERASED: return erased ? 8'hFF : 8'h00;
			`AWT_TB_HOT0: return hot_ok ? hot[23:16] : 8'h00;
			`AWT_TB_HOT1: return hot_ok ? hot[15:8] : 8'h00;
			`AWT_TB_HOT2: return hot_ok ? hot[7:0] : 8'h00;
			default: return 8'h00;
		endcase
	endfunction : tbyte

	function automatic logic [8:0] blk_size(input logic [7:0] m, input logic [8:0] left);
		return ({1'b0, m} < left) ? {1'b0, m} : left;
	endfunction : blk_size

	function automatic awt_tf_t advance(input awt_tf_t tf);
		awt_tf_t t;
		logic [27:0] a;
		t = tf;
		a = {tf.dh[3:0], tf.cyh, tf.cyl, tf.sn} + 28'h0000001;
		if (tf.dh[`AWT_DH_LBA]) begin
			{t.dh[3:0], t.cyh, t.cyl, t.sn} = a;
		end else begin
			t.sn = tf.sn + 8'h01;
		end
		return t;
	endfunction : advance

	// ----------------------------------------------------------------
	// bus and pin decode
	// ----------------------------------------------------------------
	awt_st_t r;
	awt_st_t next_r;
	logic aph;
	logic [3:0] aidx;
	logic cmd_go;
	logic [7:0] cmd_byte;
	logic iowr_rise;
	logic word_ok;
	logic [15:0] tword;

	assign aph = hsel_i && hready_i && htrans_i[1];
	assign aidx = haddr_i[5:2];
	assign cmd_byte = hwdata_i[7:0];
	assign cmd_go = r.wr_pend && r.wr_idx == `AWT_IDX_CMD && !r.bsy
		&& r.tf.dh[`AWT_DH_DRV] == DRIVE_ID;
	// write strobe ends on the rising edge of the filtered strobe
	assign iowr_rise = r.s_iowr[2] == r.s_iowr[1] && r.s_iowr[2] && !r.iowr_f;
	assign word_ok = r.st == AWT_XFER && (r.is_dma
		? (iowr_rise && !r.ack_f)
		: (r.drq && r.wr_pend && r.wr_idx == `AWT_IDX_DATA));
	assign tword = {tbyte(r.tf, {r.widx, 1'b1}, erased_i, hot_count_i, hot_valid_i),
		tbyte(r.tf, {r.widx, 1'b0}, erased_i, hot_count_i, hot_valid_i)};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic fin_ok;
		logic fin_err;
		logic [8:0] left0;
		logic [7:0] st_byte;
		next_r = r;
		fin_ok = 1'b0;
		fin_err = 1'b0;
		left0 = (r.tf.sc == 8'h00) ? 9'h100 : {1'b0, r.tf.sc};
		st_byte = 8'h00;
		st_byte[`AWT_ST_BSY] = r.bsy;
		st_byte[`AWT_ST_RDY] = 1'b1;
		st_byte[`AWT_ST_DRQ] = r.drq;
		st_byte[`AWT_ST_ERR] = r.errf;

		// three-stage pin synchronisers
		next_r.s_ack = {r.s_ack[1:0], dmack_n_i};
		next_r.s_iowr = {r.s_iowr[1:0], iowr_n_i};
		next_r.d1 = dd_i;
		next_r.d2 = r.d1;
		next_r.d3 = r.d2;
		if (r.s_ack[2] == r.s_ack[1]) begin
			next_r.ack_f = r.s_ack[2];
		end
		if (r.s_iowr[2] == r.s_iowr[1]) begin
			next_r.iowr_f = r.s_iowr[2];
		end
		if (r.s_iowr[2] == r.s_iowr[1] && !r.s_iowr[2]) begin
			next_r.dlat = r.d3;
		end
		next_r.mrd = r.wbuf[media_idx_i];

		// bus address phase: reads latched here with their side effects
		next_r.wr_pend = aph && hwrite_i;
		next_r.wr_idx = aidx;
		if (aph && !hwrite_i) begin
			unique case (aidx)
				`AWT_IDX_DATA: next_r.hrdata = {16'h0000, (r.st == AWT_TRANS) ? tword : 16'h0000};
				`AWT_IDX_FEAT: next_r.hrdata = {24'h000000, r.err};
				`AWT_IDX_SC: next_r.hrdata = {24'h000000, r.tf.sc};
				`AWT_IDX_SN: next_r.hrdata = {24'h000000, r.tf.sn};
				`AWT_IDX_CYL: next_r.hrdata = {24'h000000, r.tf.cyl};
				`AWT_IDX_CYH: next_r.hrdata = {24'h000000, r.tf.cyh};
				`AWT_IDX_DH: next_r.hrdata = {24'h000000, r.tf.dh};
				`AWT_IDX_CMD: next_r.hrdata = {24'h000000, st_byte};
				`AWT_IDX_CFG: next_r.hrdata = {16'h0000, r.mult_cnt, 6'h00, r.mult_en, r.eight_bit};
				default: next_r.hrdata = 32'h00000000;
			endcase
			if (aidx == `AWT_IDX_CMD) begin
				next_r.intrq = 1'b0;
			end
			if (aidx == `AWT_IDX_DATA && r.st == AWT_TRANS) begin
				next_r.widx = r.widx + 8'h01;
				if (r.widx == `AWT_LAST_WORD) begin
					next_r.drq = 1'b0;
					next_r.st = AWT_IDLE;
				end
			end
		end

		// bus data phase: register writes
		if (r.wr_pend && !r.bsy) begin
			unique case (r.wr_idx)
				`AWT_IDX_FEAT: next_r.tf.feat = hwdata_i[7:0];
				`AWT_IDX_SC: next_r.tf.sc = hwdata_i[7:0];
				`AWT_IDX_SN: next_r.tf.sn = hwdata_i[7:0];
				`AWT_IDX_CYL: next_r.tf.cyl = hwdata_i[7:0];
				`AWT_IDX_CYH: next_r.tf.cyh = hwdata_i[7:0];
				`AWT_IDX_DH: next_r.tf.dh = hwdata_i[7:0] | `AWT_DH_FIXED;
				`AWT_IDX_CFG: begin
					if (r.st == AWT_IDLE) begin
						next_r.eight_bit = hwdata_i[`AWT_CFG_8BIT];
						next_r.mult_cnt = hwdata_i[`AWT_CFG_CNT_LSB +: 8];
						// only supported nonzero counts enable multiple mode
						next_r.mult_en = hwdata_i[`AWT_CFG_CNT_LSB +: 8] != 8'h00
							&& int'(hwdata_i[`AWT_CFG_CNT_LSB +: 8]) <= MAX_MULT;
					end
				end
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// command engine
		// ------------------------------------------------------------
		if (cmd_go) begin
			next_r.cmd = cmd_byte;
			next_r.err = 8'h00;
			next_r.errf = 1'b0;
			next_r.err_pend = 1'b0;
			next_r.first_blk = 1'b1;
			next_r.blk_start = 1'b1;
			next_r.is_dma = 1'b0;
			next_r.widx = 8'h00;
			next_r.dly = `AWT_SETUP_CYC;
			next_r.intrq = 1'b0;
			next_r.bsy = 1'b1;
			next_r.drq = 1'b0;
			next_r.dmarq = 1'b0;
			next_r.left = left0;
			next_r.blk_left = left0;
			next_r.st = AWT_SETUP;
			unique case (cmd_byte)
				`AWT_OP_TRANSLATE: ;
				`AWT_OP_WEAR: begin
					next_r.tf.sc = 8'h00;
					fin_ok = 1'b1;
				end
				`AWT_OP_WBUF: begin
					next_r.left = 9'h001;
					next_r.blk_left = 9'h001;
				end
				`AWT_OP_WDMA: begin
					next_r.is_dma = 1'b1;
					if (r.eight_bit) begin
						fin_err = 1'b1;
					end
				end
				`AWT_OP_WMULT: begin
					next_r.blk_left = blk_size(r.mult_cnt, left0);
					if (!r.mult_en) begin
						fin_err = 1'b1;
					end
				end
				default: fin_err = 1'b1;
			endcase
			if (fin_err) begin
				next_r.err[`AWT_ER_ABRT] = 1'b1;
			end
		end else begin
			unique case (r.st)
				AWT_IDLE: ;
				AWT_SETUP: begin
					next_r.dly = r.dly - 6'h01;
					if (r.dly == 6'h01) begin
						next_r.first_blk = 1'b0;
						next_r.blk_start = 1'b0;
						if (r.cmd == `AWT_OP_TRANSLATE) begin
							next_r.st = AWT_TRANS;
							next_r.bsy = 1'b0;
							next_r.drq = 1'b1;
							next_r.intrq = 1'b1;
						end else begin
							next_r.st = AWT_XFER;
							if (r.is_dma) begin
								next_r.dmarq = 1'b1;
							end else begin
								next_r.bsy = 1'b0;
								next_r.drq = 1'b1;
							end
							if (r.cmd == `AWT_OP_WMULT && r.blk_start && !r.first_blk) begin
								next_r.intrq = 1'b1;
							end
						end
					end
				end
				AWT_XFER: begin
					if (word_ok) begin
						next_r.wbuf[r.widx] = r.is_dma ? r.dlat : hwdata_i[15:0];
						next_r.widx = r.widx + 8'h01;
						if (r.widx == `AWT_LAST_WORD) begin
							next_r.drq = 1'b0;
							next_r.dmarq = 1'b0;
							next_r.bsy = 1'b1;
							if (r.cmd == `AWT_OP_WBUF) begin
								fin_ok = 1'b1;
							end else if (r.err_pend) begin
								// rest of a failed block is taken and dropped
								next_r.blk_left = r.blk_left - 9'h001;
								next_r.dly = 6'h01;
								next_r.st = AWT_SETUP;
								fin_err = r.blk_left == 9'h001;
							end else begin
								next_r.st = AWT_PROG;
							end
						end
					end
				end
				AWT_PROG: begin
					if (media_done_i) begin
						next_r.widx = 8'h00;
						next_r.dly = 6'h01;
						next_r.st = AWT_SETUP;
						if (media_err_i) begin
							// address and count stay on the failing sector
							next_r.err_pend = 1'b1;
							next_r.blk_left = r.blk_left - 9'h001;
							fin_err = r.blk_left == 9'h001 || r.is_dma;
						end else begin
							next_r.tf = advance(r.tf);
							next_r.tf.sc = r.tf.sc - 8'h01;
							next_r.left = r.left - 9'h001;
							if (r.left == 9'h001) begin
								fin_ok = 1'b1;
							end else if (r.blk_left == 9'h001) begin
								next_r.blk_left = blk_size(r.mult_cnt, r.left - 9'h001);
								next_r.blk_start = 1'b1;
							end else begin
								next_r.blk_left = r.blk_left - 9'h001;
							end
						end
					end
				end
				AWT_TRANS: ;
				default: next_r.st = AWT_IDLE;
			endcase
			if (fin_err) begin
				next_r.err[`AWT_ER_WRF] = 1'b1;
			end
		end

		// completion: a set here wins over a status-read clear
		if (fin_ok || fin_err) begin
			next_r.st = AWT_IDLE;
			next_r.bsy = 1'b0;
			next_r.drq = 1'b0;
			next_r.dmarq = 1'b0;
			next_r.errf = fin_err;
			next_r.intrq = 1'b1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0;
			r.tf.sc <= `AWT_SC_RST;
			r.tf.sn <= `AWT_SN_RST;
			r.tf.dh <= `AWT_DH_RST;
			r.s_ack <= 3'h7;
			r.s_iowr <= 3'h7;
			r.ack_f <= 1'b1;
			r.iowr_f <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = r.hrdata;
	assign dmarq_o = r.dmarq;
	assign intrq_o = r.intrq;
	assign media_o = '{req: r.st == AWT_PROG, lba: lba_of(r.tf)};
	assign media_data_o = r.mrd;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_busy_in_time: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_go && cmd_byte == `AWT_OP_WMULT |-> ##[1:BSY_CYC] (r.bsy || r.errf))
		else $error("busy not raised in time after write-multiple");

	a_wear_zero: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_go && cmd_byte == `AWT_OP_WEAR |=> r.tf.sc == 8'h00 && r.intrq && !r.bsy)
		else $error("wear-level did not return zero count");

	a_dma_abort: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_go && cmd_byte == `AWT_OP_WDMA && r.eight_bit
		|=> r.errf && r.err[`AWT_ER_ABRT] && !r.dmarq)
		else $error("Write DMA not aborted in 8-bit mode");

	a_mult_abort: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_go && cmd_byte == `AWT_OP_WMULT && !r.mult_en |=> r.errf && r.st == AWT_IDLE)
		else $error("write-multiple not aborted without block count");

	a_dma_irq_end: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(r.intrq) && r.is_dma |-> r.st == AWT_IDLE)
		else $error("Write DMA interrupt before completion");

	a_dmarq_xfer: assert property (@(posedge clock_i) disable iff (rst_i)
		r.dmarq |-> r.st == AWT_XFER && r.is_dma && r.bsy)
		else $error("DMA request outside a DMA transfer");

	a_no_first_irq: assert property (@(posedge clock_i) disable iff (rst_i)
		cmd_go && cmd_byte == `AWT_OP_WBUF |=> !r.intrq [*3])
		else $error("interrupt before first write transfer");

	a_err_residue: assert property (@(posedge clock_i) disable iff (rst_i)
		r.st == AWT_PROG && media_done_i && media_err_i
		|=> r.tf.sc == $past(r.tf.sc) && r.tf.sn == $past(r.tf.sn) && r.err_pend)
		else $error("error did not freeze address and count");

	a_trans_end: assert property (@(posedge clock_i) disable iff (rst_i)
		r.st == AWT_TRANS && aph && !hwrite_i && aidx == `AWT_IDX_DATA
		&& r.widx == `AWT_LAST_WORD |=> r.st == AWT_IDLE && !r.drq)
		else $error("translate buffer not closed after 256 words");

	c_translate: cover property (@(posedge clock_i) disable iff (rst_i)
		r.st == AWT_TRANS ##1 r.st == AWT_IDLE);
	c_dma_done: cover property (@(posedge clock_i) disable iff (rst_i)
		r.is_dma && r.st == AWT_PROG ##1 r.st == AWT_IDLE && !r.errf);
	c_mult_err: cover property (@(posedge clock_i) disable iff (rst_i)
		r.cmd == `AWT_OP_WMULT && $rose(r.errf));

endmodule : awt_cmd

// >>> tb/awt_media_model.sv
`timescale 1ns/1ps
module awt_media_model (
	input wire logic clock_i,
	input wire logic req_i,
	input wire logic fail_i,
	input wire logic slow_i,
	input wire logic [15:0] data_i,
	output logic [7:0] idx_o,
	output logic done_o,
	output logic err_o,
	output logic [31:0] sum_o
);
	int n;
	initial begin
		idx_o = 8'h00;
		done_o = 1'b0;
		err_o = 1'b1;
		sum_o = 32'h0;
	end
	// ----------------------------------------
	// sector program: sweep buffer, then done
	// ----------------------------------------
	always begin
		@(posedge clock_i);
		if (req_i === 1'b1) begin
			for (int i = 0; i < 257; i++) begin
				if (i < 256) idx_o <= i[7:0];
				@(posedge clock_i);
				// buffer word arrives two edges after its index
				if (i > 0) sum_o = sum_o + {16'h0, data_i};
			end
			n = slow_i ? 30 : 1;
			repeat (n) @(posedge clock_i);
			done_o <= 1'b1;
			err_o <= fail_i;
			@(posedge clock_i);
			done_o <= 1'b0;
			// status line is meaningless outside done
			err_o <= ~fail_i;
			@(posedge clock_i);
		end
	end
endmodule : awt_media_model

// >>> tb/tb_ata_write_translate_cmds.sv
`timescale 1ns/1ps
module tb_ata_write_translate_cmds import awt_pkg::*; ;
	localparam int HD = 3;
	localparam int SN = 5;
	localparam int CY = 258;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic hreadyout_o, hresp_o, dmarq_o, intrq_o, media_done_i, media_err_i;
	logic dmack_n_i = 1'b1, iowr_n_i = 1'b1, erased_i = 1'b0, hot_valid_i = 1'b0;
	logic fail = 1'b0, slow = 1'b0;
	logic [15:0] dd_i = 16'h0, media_data_o;
	logic [23:0] hot_count_i = 24'h0;
	logic [7:0] media_idx_i;
	logic [31:0] hrdata_o, msum, seed = 32'd2156, rd_val, s0, es, w;
	awt_media_t media_o;
	int bad_count = 0, n_tests = 0, mcount = 0, m0;
	logic [31:0] exp_q[$], msk_q[$];
	logic [27:0] lba_q[$];
	string nm_q[$];
	event rd_ev;

	always #5 clock_i = ~clock_i;

	awt_cmd dut (.clock_i(clock_i),
		.rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
		.dmarq_o(dmarq_o), .dmack_n_i(dmack_n_i), .iowr_n_i(iowr_n_i), .dd_i(dd_i),
		.intrq_o(intrq_o), .media_o(media_o), .media_done_i(media_done_i),
		.media_err_i(media_err_i), .media_idx_i(media_idx_i), .media_data_o(media_data_o),
		.erased_i(erased_i), .hot_count_i(hot_count_i), .hot_valid_i(hot_valid_i));

	awt_media_model media (.clock_i(clock_i), .req_i(media_o.req), .fail_i(fail),
		.slow_i(slow), .data_i(media_data_o), .idx_o(media_idx_i), .done_o(media_done_i),
		.err_o(media_err_i), .sum_o(msum));

	// ----------------------------------------
	// checking and bus helpers
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d,
			output logic [31:0] r);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= {26'h0, idx, 2'h0};
		hwrite_i <= wr;
		hsize_i <= 3'h2;
		@(posedge clock_i);
		while (hreadyout_o !== 1'b1) @(posedge clock_i);
		htrans_i <= 2'h0;
		hwdata_i <= d;
		@(posedge clock_i);
		while (hreadyout_o !== 1'b1) @(posedge clock_i);
		r = hrdata_o;
	endtask : bus

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, idx, d, r);
	endtask : wr

	task automatic rd(input logic [3:0] idx, input logic [31:0] e, input logic [31:0] m,
			input string nm);
		exp_q.push_back(e);
		msk_q.push_back(m);
		nm_q.push_back(nm);
		bus(1'b0, idx, 32'h0, rd_val);
		->rd_ev;
	endtask : rd

	task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
		logic [31:0] r;
		int k;
		k = 0;
		do begin
			bus(1'b0, 4'h7, 32'h0, r);
			k++;
		end while ((r[7:0] & m) !== v && k < 3000);
		check("status wait", {24'h0, r[7:0] & m}, {24'h0, v});
	endtask : wait_st

	task automatic wait_irq();
		int k;
		k = 0;
		while (intrq_o !== 1'b1 && k < 8000) begin
			@(posedge clock_i);
			k++;
		end
		check("intrq", {31'h0, intrq_o}, 32'h1);
	endtask : wait_irq

	task automatic tfile(input logic [7:0] sc, sn, cyl, cyh, dh);
		wr(4'h2, {24'h0, sc});
		wr(4'h3, {24'h0, sn});
		wr(4'h4, {24'h0, cyl});
		wr(4'h5, {24'h0, cyh});
		wr(4'h6, {24'h0, dh});
	endtask : tfile

	function automatic logic [7:0] tbyte(input int n, input logic lba_mode);
		int l;
		int c;
		int h;
		int s;
		l = (CY * 16 + HD) * 63 + SN - 1;
		c = CY;
		h = HD;
		s = SN;
		if (lba_mode) begin
			// same registers read as a logical address, head field on top
			l = (HD << 24) | (CY << 8) | SN;
			c = l / (16 * 63);
			h = (l / 63) % 16;
			s = l % 63 + 1;
		end
		case (n)
			0: return c[15:8];
			1: return c[7:0];
			2: return h[7:0];
			3: return s[7:0];
			4: return l[23:16];
			5: return l[15:8];
			6: return l[7:0];
			19: return erased_i ? 8'hFF : 8'h00;
			24: return hot_valid_i ? hot_count_i[23:16] : 8'h00;
			25: return hot_valid_i ? hot_count_i[15:8] : 8'h00;
			26: return hot_valid_i ? hot_count_i[7:0] : 8'h00;
			default: return 8'h00;
		endcase
	endfunction : tbyte

	initial forever begin
		@(rd_ev);
		check(nm_q.pop_front(), rd_val & msk_q.pop_front(), exp_q.pop_front());
		check("hresp", {31'h0, hresp_o}, 32'h0);
	end

	always @(posedge media_o.req) begin
		mcount++;
		check("media lba", {4'h0, media_o.lba}, {4'h0, lba_q.pop_front()});
	end

	initial begin
		repeat (60000) @(posedge clock_i);
		bad_count++;
		final_report();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rd(4'h2, 32'h01, 32'hFF, "sector count");
		rd(4'h6, 32'hA0, 32'hFF, "drive head");
		rd(4'h7, 32'h40, 32'hFF, "status");
		rd(4'hF, 32'h0, 32'hFFFFFFFF, "unmapped");
		wr(4'h6, 32'h00);
		rd(4'h6, 32'hA0, 32'hFF, "drive head");
		wr(4'h2, 32'h05);
		wr(4'h7, 32'hF5);
		wait_irq();
		rd(4'h2, 32'h00, 32'hFF, "wear count");
		for (int t = 0; t < 2; t++) begin
			w = xs();
			erased_i <= (t == 0);
			hot_valid_i <= (t == 0);
			hot_count_i <= w[23:0];
			tfile(8'h01, SN[7:0], CY[7:0], CY[15:8], (t == 0) ? 8'hA3 : 8'hE3);
			wr(4'h7, 32'h87);
			wait_st(8'h88, 8'h08);
			for (int i = 0; i < 256; i++) begin
				rd(4'h0, {16'h0, tbyte(2 * i + 1, t == 1), tbyte(2 * i, t == 1)},
					32'hFFFF, "translate");
			end
			wait_st(8'h88, 8'h00);
		end
		m0 = mcount;
		wr(4'h7, 32'hE8);
		repeat (8) @(posedge clock_i);
		check("intrq", {31'h0, intrq_o}, 32'h0);
		wait_st(8'h88, 8'h08);
		for (int i = 0; i < 256; i++) begin
			w = xs();
			wr(4'h0, {16'h0, w[15:0]});
		end
		wait_irq();
		check("programs", mcount, m0);
		rd(4'h7, 32'h40, 32'hFF, "status");
		wr(4'h8, 32'h01);
		tfile(8'h01, 8'h00, 8'h00, 8'h00, 8'hE0);
		wr(4'h7, 32'hCA);
		wait_irq();
		rd(4'h7, 32'h41, 32'hFF, "status");
		rd(4'h1, 32'h04, 32'h04, "abort");
		check("programs", mcount, m0);
		wr(4'h8, 32'h00);
		slow <= 1'b1;
		tfile(8'h02, 8'h67, 8'h45, 8'h23, 8'hE1);
		lba_q.push_back(28'h1234567);
		lba_q.push_back(28'h1234568);
		s0 = msum;
		es = 32'h0;
		wr(4'h7, 32'hCA);
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 5000 && dmarq_o !== 1'b1; k++) @(posedge clock_i);
			check("dmarq", {31'h0, dmarq_o}, 32'h1);
			check("intrq", {31'h0, intrq_o}, 32'h0);
			dmack_n_i <= 1'b0;
			for (int i = 0; i < 256; i++) begin
				w = xs();
				es = es + {16'h0, w[15:0]};
				dd_i <= w[15:0];
				iowr_n_i <= 1'b0;
				repeat (4) @(posedge clock_i);
				iowr_n_i <= 1'b1;
				repeat (4) @(posedge clock_i);
			end
			for (int k = 0; k < 50 && dmarq_o !== 1'b0; k++) @(posedge clock_i);
			check("dmarq", {31'h0, dmarq_o}, 32'h0);
			dmack_n_i <= 1'b1;
		end
		wait_irq();
		check("dma data", msum - s0, es);
		check("programs", mcount, m0 + 2);
		rd(4'h7, 32'h40, 32'hFF, "status");
		tfile(8'h02, 8'h10, 8'h00, 8'h00, 8'hE0);
		wr(4'h7, 32'hC5);
		wait_irq();
		rd(4'h7, 32'h41, 32'hFF, "status");
		rd(4'h1, 32'h04, 32'h04, "abort");
		slow <= 1'b0;
		wr(4'h8, 32'h0100);
		rd(4'h8, 32'h0102, 32'hFFFF, "config");
		tfile(8'h03, 8'h10, 8'h00, 8'h00, 8'hE0);
		lba_q.push_back(28'h0000010);
		lba_q.push_back(28'h0000011);
		wr(4'h7, 32'hC5);
		for (int s = 0; s < 2; s++) begin
			if (s == 0) begin
				repeat (8) @(posedge clock_i);
				check("intrq", {31'h0, intrq_o}, 32'h0);
				wait_st(8'h88, 8'h08);
			end else begin
				wait_irq();
				rd(4'h7, 32'h48, 32'hFF, "status");
				fail <= 1'b1;
			end
			for (int i = 0; i < 256; i++) begin
				w = xs();
				wr(4'h0, {16'h0, w[15:0]});
			end
		end
		wait_irq();
		rd(4'h7, 32'h41, 32'hFF, "status");
		rd(4'h1, 32'h40, 32'h40, "fault");
		rd(4'h2, 32'h02, 32'hFF, "residual");
		rd(4'h3, 32'h11, 32'hFF, "fail sector");
		repeat (400) @(posedge clock_i);
		check("programs", mcount, m0 + 4);
		final_report();
	end
endmodule : tb_ata_write_translate_cmds
